// ### csi_pkg.sv
// What this block does
// - A transaction opens with a start, seven address bits and a write bit, acknowledged next slot.
// - An eight-bit command code follows, msb first, and is acknowledged.
// - A byte write sends one data byte, it is acknowledged and stored at the offset, then stop.
// - A byte read repeats start and address with read, is acknowledged, one byte is sent, NACK, stop.
// - Every control bit, reserved ones too, resets to its power-up value.
// - Byte 0 bit 2 gates the differential output pair, one drives, powers up set.
// - Byte 2 bit 7 selects spread depth, zero -0.35 percent, one -0.5 percent, powers up one.
// - Byte 2 bit 2 turns spread modulation on, powers up cleared.
// - Byte 6 bit 6 enters test clock mode when set, powers up cleared.
// - In test mode byte 6 bit 7 picks high impedance (0) or divided reference (1).
// - Byte 7 reads revision code in bits 7:4 and vendor code in bits 3:0.
// - Command bit 7 set means byte operation, bits 6:5 must be 00, bits 4:0 are the offset.
// - The device answers only to the address bytes 11010010 (write) and 11010011 (read), direction bit included.
package csi_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam int REG_COUNT = 8;
  localparam logic [2:0] OFS_OUTPUT = 3'h0;
  localparam logic [2:0] OFS_SPREAD = 3'h2;
  localparam logic [2:0] OFS_TEST = 3'h6;
  localparam logic [2:0] OFS_IDENT = 3'h7;
  localparam int BIT_GATE = 2;
  localparam int BIT_DEPTH = 7;
  localparam int BIT_SPREAD = 2;
  localparam int BIT_TEST_MODE = 6;
  localparam int BIT_TEST_SEL = 7;
  localparam int CMD_BYTE_OP = 7;
  localparam logic [63:0] RESET_VALUES = 64'h0013_0001_AFEB_007C;
  localparam logic [3:0] REVISION_CODE = 4'h5;  // Arbitrary value
  localparam logic [3:0] VENDOR_CODE = 4'hA;    // Arbitrary value

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_RX = 5'b00100,
    ST_ACK = 5'b01000,
    ST_TX = 5'b10000
  } csi_state_t;

  typedef struct packed {
    logic clock_output_gate;
    logic spread_depth_select;
    logic spread_modulation_enable;
    logic test_mode;
    logic test_select;
  } csi_ctrl_t;
endpackage

// ### csi_ctrl.sv
`timescale 1ns/1ns
module csi_ctrl (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_serial_clock,
  input wire logic i_serial_data_pin,
  output logic o_serial_data_pin,
  output logic o_serial_data_oe,
  output csi_pkg::csi_ctrl_t o_ctrl,
  output logic o_output_drive,
  output logic o_output_ref_div
);
  // ****************
  // Input synchronisers
  // ****************
  logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
  logic scl_prev_q, scl_prev_d, sda_prev_q, sda_prev_d;
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

  always_comb begin
    scl_sync_d = {scl_sync_q[0], i_serial_clock};
    sda_sync_d = {sda_sync_q[0], i_serial_data_pin};
    scl_prev_d = scl_sync_q[1];
    sda_prev_d = sda_sync_q[1];
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= scl_sync_d;
      sda_sync_q <= sda_sync_d;
      scl_prev_q <= scl_prev_d;
      sda_prev_q <= sda_prev_d;
    end
  end

  assign scl = scl_sync_q[1];
  assign sda = sda_sync_q[1];
  assign scl_rise = scl && !scl_prev_q;
  assign scl_fall = !scl && scl_prev_q;
  // Start and stop are data edges while the bus clock stays high
  assign start_c = scl && scl_prev_q && sda_prev_q && !sda;
  assign stop_c = scl && scl_prev_q && !sda_prev_q && sda;

  // ****************
  // Protocol engine and register bank
  // ****************
  csi_pkg::csi_state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] count_q, count_d;
  logic [1:0] phase_q, phase_d;
  logic [2:0] offset_q, offset_d;
  logic byte_op_q, byte_op_d, nack_q, nack_d, reading_q, reading_d;
  logic sda_oe_q, sda_oe_d;
  logic [7:0] regs_q [csi_pkg::REG_COUNT];
  logic [7:0] regs_d [csi_pkg::REG_COUNT];
  logic [7:0] rd_byte;

  // Identification byte is fixed, writes to it are dropped
  always_comb begin
    rd_byte = regs_q[offset_q];
    if (offset_q == csi_pkg::OFS_IDENT) begin
      rd_byte = {csi_pkg::REVISION_CODE, csi_pkg::VENDOR_CODE};
    end
  end

  // Bits shift in on bus clock rises, every action but start, stop and the acknowledge sample waits for the fall
  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    count_d = count_q;
    phase_d = phase_q;
    offset_d = offset_q;
    byte_op_d = byte_op_q;
    nack_d = nack_q;
    reading_d = reading_q;
    sda_oe_d = sda_oe_q;
    for (int i = 0; i < csi_pkg::REG_COUNT; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (start_c) begin
      state_d = csi_pkg::ST_ADDR;
      count_d = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      state_d = csi_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      // A read needs its command in the same transaction
      phase_d = 2'h0;
    end else begin
      case (state_q)
        csi_pkg::ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        csi_pkg::ST_ADDR, csi_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda};
            count_d = count_q + 4'h1;
          end else if (scl_fall && count_q == 4'h8) begin
            count_d = 4'h0;
            state_d = csi_pkg::ST_ACK;
            sda_oe_d = 1'b1;
            if (state_q == csi_pkg::ST_ADDR) begin
              reading_d = shift_q[0];
              if (shift_q[7:1] != csi_pkg::SLAVE_ADDR) begin
                state_d = csi_pkg::ST_IDLE;
                sda_oe_d = 1'b0;
              end else if (!shift_q[0]) begin
                phase_d = 2'h0;
              end else if (phase_q != 2'h1 || !byte_op_q) begin
                state_d = csi_pkg::ST_IDLE;
                sda_oe_d = 1'b0;
              end
            end else if (phase_q == 2'h0) begin
              byte_op_d = shift_q[csi_pkg::CMD_BYTE_OP] && shift_q[6:5] == 2'h0;
              offset_d = shift_q[2:0];
              if (!byte_op_d || shift_q[4:3] != 2'h0) begin
                state_d = csi_pkg::ST_IDLE;
                sda_oe_d = 1'b0;
              end else begin
                phase_d = 2'h1;
              end
            end else if (phase_q == 2'h1) begin
              if (offset_q != csi_pkg::OFS_IDENT) begin
                regs_d[offset_q] = shift_q;
              end
              phase_d = 2'h2;
            end else begin
              state_d = csi_pkg::ST_IDLE;
              sda_oe_d = 1'b0;
            end
          end
        end
        csi_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (reading_q && phase_q == 2'h1) begin
              state_d = csi_pkg::ST_TX;
              shift_d = rd_byte;
              sda_oe_d = !rd_byte[7];
              phase_d = 2'h3;
            end else begin
              state_d = csi_pkg::ST_RX;
              sda_oe_d = 1'b0;
            end
          end
        end
        csi_pkg::ST_TX: begin
          // Ninth rise samples the controller's acknowledge
          if (scl_rise) begin
            count_d = count_q + 4'h1;
            if (count_q == 4'h8) begin
              nack_d = sda;
            end
          end else if (scl_fall) begin
            if (count_q == 4'h8) begin
              sda_oe_d = 1'b0;
            end else if (count_q == 4'h9) begin
              state_d = csi_pkg::ST_IDLE;
              sda_oe_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sda_oe_d = !shift_q[6];
            end
          end
        end
        default: begin
          state_d = csi_pkg::ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= csi_pkg::ST_IDLE;
      shift_q <= 8'h00;
      count_q <= 4'h0;
      phase_q <= 2'h0;
      offset_q <= 3'h0;
      byte_op_q <= 1'b0;
      nack_q <= 1'b0;
      reading_q <= 1'b0;
      sda_oe_q <= 1'b0;
      for (int i = 0; i < csi_pkg::REG_COUNT; i++) begin
        regs_q[i] <= csi_pkg::RESET_VALUES[i*8 +: 8];
      end
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      count_q <= count_d;
      phase_q <= phase_d;
      offset_q <= offset_d;
      byte_op_q <= byte_op_d;
      nack_q <= nack_d;
      reading_q <= reading_d;
      sda_oe_q <= sda_oe_d;
      for (int i = 0; i < csi_pkg::REG_COUNT; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ****************
  // Control outputs
  // ****************
  // Open drain: the pin only ever pulls low
  assign o_serial_data_pin = 1'b0;
  assign o_serial_data_oe = sda_oe_q;
  assign o_ctrl.clock_output_gate = regs_q[csi_pkg::OFS_OUTPUT][csi_pkg::BIT_GATE];
  assign o_ctrl.spread_depth_select = regs_q[csi_pkg::OFS_SPREAD][csi_pkg::BIT_DEPTH];
  assign o_ctrl.spread_modulation_enable = regs_q[csi_pkg::OFS_SPREAD][csi_pkg::BIT_SPREAD];
  assign o_ctrl.test_mode = regs_q[csi_pkg::OFS_TEST][csi_pkg::BIT_TEST_MODE];
  assign o_ctrl.test_select = regs_q[csi_pkg::OFS_TEST][csi_pkg::BIT_TEST_SEL];
  // Test mode overrides the output gate
  assign o_output_drive = o_ctrl.test_mode ? o_ctrl.test_select : o_ctrl.clock_output_gate;
  assign o_output_ref_div = o_ctrl.test_mode && o_ctrl.test_select;
endmodule

// ### csi_ctrl_checker.sv
`timescale 1ns/1ns
module csi_ctrl_checker (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_serial_clock,
  input wire logic i_serial_data_pin,
  input wire logic o_serial_data_pin,
  input wire logic o_serial_data_oe,
  input wire csi_pkg::csi_ctrl_t o_ctrl,
  input wire logic o_output_drive,
  input wire logic o_output_ref_div
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  AST_REF_DIV: assert property (o_output_ref_div == (o_ctrl.test_mode && o_ctrl.test_select))
    else $error("ref div wrong");
  AST_DRIVE: assert property (o_output_drive ==
    (o_ctrl.test_mode ? o_ctrl.test_select : o_ctrl.clock_output_gate))
    else $error("drive wrong");
  AST_OPEN_DRAIN: assert property (o_serial_data_pin == 1'b0)
    else $error("data pin driven high");
  AST_RESET_CTRL: assert property ($rose(i_rst_b) |-> o_ctrl == 5'h18)
    else $error("reset value wrong");
  AST_OE_SCL_LOW: assert property ($changed(o_serial_data_oe) |-> !i_serial_clock)
    else $error("data changed with clock high");
  AST_CTRL_SCL_LOW: assert property ($changed(o_ctrl) |-> !i_serial_clock)
    else $error("control changed with clock high");
  AST_CTRL_IN_ACK: assert property ($changed(o_ctrl) |-> o_serial_data_oe)
    else $error("control changed outside ack");
  AST_OE_BOUNDED: assert property ($rose(o_serial_data_oe) |-> ##[1:300] !o_serial_data_oe)
    else $error("data line held too long");
  cover property ($rose(o_serial_data_oe));
  cover property ($rose(o_output_ref_div));
  cover property ($fell(o_output_drive));
endmodule
bind csi_ctrl csi_ctrl_checker u_chk (.i_clock, .i_rst_b, .i_serial_clock, .i_serial_data_pin,
  .o_serial_data_pin, .o_serial_data_oe, .o_ctrl, .o_output_drive, .o_output_ref_div);

// ### csi_host.sv
`timescale 1ns/1ns
module csi_host (
  input wire logic i_clock,
  input wire logic i_dut_oe,
  output logic o_scl,
  output logic o_sda
);
  logic pull;
  // Open drain with pull-up
  assign o_sda = !(pull || i_dut_oe);
  initial begin
    o_scl = 1'b1;
    pull = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic bit_io(input logic b, output logic r);
    hp(2);
    pull = !b;
    hp(6);
    o_scl = 1'b1;
    hp(8);
    r = o_sda;
    o_scl = 1'b0;
  endtask
  task automatic start();
    hp(6);
    pull = 1'b0;
    hp(4);
    o_scl = 1'b1;
    hp(8);
    pull = 1'b1;
    hp(8);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    hp(6);
    pull = 1'b1;
    hp(4);
    o_scl = 1'b1;
    hp(8);
    pull = 1'b0;
    hp(8);
  endtask
  // Byte msb first, then the ninth slot
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(nine, s);
    ack = !s;
  endtask
endmodule

// ### tb_clock_synth_i2c_control.sv
`timescale 1ns/1ns
module tb_clock_synth_i2c_control;
  logic i_clock;
  logic i_rst_b;
  logic scl, sda, oe, drive, ref_div;
  csi_pkg::csi_ctrl_t ctrl;
  int err_count;
  int samples_checked;
  logic [7:0] rv;
  logic [2:0] acks;
  logic [7:0] pup [7] = '{8'h7c, 8'h00, 8'heb, 8'haf, 8'h01, 8'h00, 8'h13};
  csi_ctrl u_dut (.i_clock, .i_rst_b, .i_serial_clock(scl), .i_serial_data_pin(sda),
    .o_serial_data_pin(), .o_serial_data_oe(oe), .o_ctrl(ctrl), .o_output_drive(drive),
    .o_output_ref_div(ref_div));
  csi_host u_host (.i_clock, .i_dut_oe(oe), .o_scl(scl), .o_sda(sda));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = !i_clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    u_host.start();
    u_host.xfer(a, 1'b1, x, acks[2]);
    u_host.xfer(c, 1'b1, x, acks[1]);
    u_host.xfer(d, 1'b1, x, acks[0]);
    u_host.stop();
  endtask
  task automatic rd(input logic [2:0] ofs);
    logic a;
    u_host.start();
    u_host.xfer(8'hd2, 1'b1, rv, acks[2]);
    u_host.xfer({5'h10, ofs}, 1'b1, rv, acks[1]);
    u_host.start();
    u_host.xfer(8'hd3, 1'b1, rv, acks[0]);
    u_host.xfer(8'hff, 1'b1, rv, a);
    u_host.stop();
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rd(3'(i));
      chk({5'h0, acks}, 8'h07);
      chk(rv, pup[i]);
    end
    rd(3'h7);
    chk(rv, {csi_pkg::REVISION_CODE, csi_pkg::VENDOR_CODE});
    chk({3'h0, ctrl}, 8'h18);
  endtask
  task automatic t_spread();
    wr(8'hd2, 8'h82, 8'h6f);
    chk({5'h0, acks}, 8'h07);
    chk({3'h0, ctrl}, 8'h14);
    rd(3'h2);
    chk(rv, 8'h6f);
  endtask
  task automatic t_gate();
    wr(8'hd2, 8'h80, 8'h78);
    chk({6'h0, drive, ref_div}, 8'h00);
    wr(8'hd2, 8'h80, 8'h7c);
    chk({6'h0, drive, ref_div}, 8'h02);
  endtask
  task automatic t_test();
    wr(8'hd2, 8'h86, 8'h53);
    chk({3'h0, ctrl}, 8'h16);
    chk({6'h0, drive, ref_div}, 8'h00);
    wr(8'hd2, 8'h86, 8'hd3);
    chk({6'h0, drive, ref_div}, 8'h03);
    wr(8'hd2, 8'h86, 8'h13);
    chk({6'h0, drive, ref_div}, 8'h02);
  endtask
  task automatic t_ident();
    wr(8'hd2, 8'h87, 8'h00);
    rd(3'h7);
    chk(rv, {csi_pkg::REVISION_CODE, csi_pkg::VENDOR_CODE});
  endtask
  task automatic t_refuse();
    wr(8'hd4, 8'h82, 8'h00);
    chk({5'h0, acks}, 8'h00);
    wr(8'hd2, 8'h02, 8'h00);
    chk({5'h0, acks}, 8'h04);
    wr(8'hd2, 8'ha2, 8'h00);
    chk({5'h0, acks}, 8'h04);
    u_host.start();
    u_host.xfer(8'hd3, 1'b1, rv, acks[0]);
    u_host.stop();
    chk({7'h0, acks[0]}, 8'h00);
    rd(3'h2);
    chk(rv, 8'h6f);
  endtask
  initial begin
    err_count = 0;
    samples_checked = 0;
    i_rst_b = 1'b0;
    repeat (8) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clock);
    t_reset();
    t_spread();
    t_gate();
    t_test();
    t_ident();
    t_refuse();
    tally_and_finish();
  end
endmodule
